/* design/adcirq_pkg.sv */
// Package of constants and types for the sequencer interrupt and overflow status block
package adcirq_pkg;

    // ****************************************************************
    // Sizes and register map
    // ****************************************************************
    localparam int          NUM_SEQ          = 4;
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] OFF_RAW_STATUS   = 12'h004;
    localparam logic [11:0] OFF_INT_MASK     = 12'h008;
    localparam logic [11:0] OFF_MASKED_CLEAR = 12'h00C;
    localparam logic [11:0] OFF_OVF_STATUS   = 12'h010;
    localparam logic [3:0]  RST_FLAGS        = 4'h0;
    localparam logic [31:0] RST_RDATA        = 32'h0000_0000;

    // ****************************************************************
    // Bus encodings and slave timing
    // ****************************************************************
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic        HRESP_OKAY       = 1'b0;
    localparam int          WAIT_STATES      = 1;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} adcirq_bus_state_e;

endpackage

/* design/adcirq_bus_if.sv */
// Interface carrying register accesses from the bus slave to the status core
`timescale 1ns/1ns
interface adcirq_bus_if;
    logic        wr_pulse;
    logic        rd_pulse;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave
    (
        output wr_pulse,
        output rd_pulse,
        output addr,
        output wdata,
        input  rdata
    );

    modport core
    (
        input  wr_pulse,
        input  rd_pulse,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface

/* design/adcirq_ahb_slave.sv */
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ns
module adcirq_ahb_slave
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    adcirq_bus_if.slave      rb
);
    adcirq_pkg::adcirq_bus_state_e state_reg;
    logic [11:0] addr_reg;
    logic        write_reg;
    logic        accept;

    // The wait state lets a write land before any following read samples
    assign accept    = hsel && (htrans == adcirq_pkg::HTRANS_NONSEQ) && hready && (state_reg != adcirq_pkg::ST_BUSY);
    assign hreadyout = (state_reg != adcirq_pkg::ST_BUSY);
    assign hresp     = adcirq_pkg::HRESP_OKAY;
    assign rb.wr_pulse = (state_reg == adcirq_pkg::ST_BUSY) && write_reg;
    assign rb.rd_pulse = (state_reg == adcirq_pkg::ST_BUSY) && !write_reg;
    assign rb.addr     = addr_reg;
    assign rb.wdata    = hwdata;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= adcirq_pkg::ST_IDLE;
        else
        begin
            unique case (state_reg)
                adcirq_pkg::ST_IDLE: state_reg <= accept ? adcirq_pkg::ST_BUSY : adcirq_pkg::ST_IDLE;
                adcirq_pkg::ST_BUSY: state_reg <= adcirq_pkg::ST_DONE;
                adcirq_pkg::ST_DONE: state_reg <= accept ? adcirq_pkg::ST_BUSY : adcirq_pkg::ST_IDLE;
                default:             state_reg <= adcirq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_reg  <= 12'h000;
            write_reg <= 1'b0;
        end
        else if (accept)
        begin
            addr_reg  <= haddr[11:0];
            write_reg <= hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= adcirq_pkg::RST_RDATA;
        else if (rb.rd_pulse)
            hrdata <= rb.rdata;
    end
endmodule

/* design/adcirq_ovf_gate.sv */
// Per-sequencer gate that drops result writes into a full FIFO
`timescale 1ns/1ns
module adcirq_ovf_gate
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] fifo_wr_req,
    input  wire logic [3:0] fifo_full,
    output logic      [3:0] fifo_wr_en,
    output logic      [3:0] ovf_event
);
    genvar i;
    generate
        for (i = 0; i < adcirq_pkg::NUM_SEQ; i++)
        begin : g_seq
            // Newest result is refused, older contents untouched
            assign fifo_wr_en[i] = fifo_wr_req[i] && !fifo_full[i];
            assign ovf_event[i]  = fifo_wr_req[i] && fifo_full[i];
        end
    endgenerate

    property p_drop_newest;
        @(posedge hclk) disable iff (!hresetn)
        (fifo_wr_req & fifo_full) != 4'h0 |-> ((fifo_wr_en & fifo_full) == 4'h0);
    endproperty
    a_drop_newest: assert property (p_drop_newest) else $error("write passed into a full fifo");
endmodule

/* design/adcirq_top.sv */
// Status core: raw and masked interrupt flags, mask, overflow flags, register decode
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
module adcirq_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [3:0]  conv_done,
    input  wire logic [3:0]  sample_irq_request,
    input  wire logic [3:0]  fifo_wr_req,
    input  wire logic [3:0]  fifo_full,
    output logic      [3:0]  fifo_wr_en,
    output logic             adc_irq
);

    // ****************************************************************
    // Bus front end and overflow gate
    // ****************************************************************
    adcirq_bus_if rb();

    logic [3:0] ovf_event;
    logic [3:0] raw_reg;
    logic [3:0] mask_reg;
    logic [3:0] ovf_reg;
    logic [3:0] raw_set;
    logic [3:0] raw_clr;
    logic [3:0] ovf_clr;
    logic [3:0] masked;
    logic       wr_mask;
    logic       wr_clear;
    logic       wr_ovf;
    logic [2:0] size_unused;

    // Only whole-word transfers are issued; size is not decoded
    assign size_unused = hsize;

    adcirq_ahb_slave u_slave
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rb        (rb.slave)
    );

    adcirq_ovf_gate u_gate
    (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .fifo_wr_req (fifo_wr_req),
        .fifo_full   (fifo_full),
        .fifo_wr_en  (fifo_wr_en),
        .ovf_event   (ovf_event)
    );

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // Writes to the raw status offset decode to nothing at all
    assign wr_mask  = rb.wr_pulse && (rb.addr == adcirq_pkg::OFF_INT_MASK);
    assign wr_clear = rb.wr_pulse && (rb.addr == adcirq_pkg::OFF_MASKED_CLEAR);
    assign wr_ovf   = rb.wr_pulse && (rb.addr == adcirq_pkg::OFF_OVF_STATUS);

    assign raw_set = conv_done & sample_irq_request;
    assign raw_clr = wr_clear ? rb.wdata[3:0] : 4'h0;
    assign ovf_clr = wr_ovf ? rb.wdata[3:0] : 4'h0;
    assign masked  = raw_reg & mask_reg;

    // ****************************************************************
    // Flags per sequencer
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < adcirq_pkg::NUM_SEQ; i++)
        begin : g_seq
            // Clearing ignores the mask, so pollers can acknowledge
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    raw_reg[i] <= 1'b0;
                else if (raw_set[i])
                    raw_reg[i] <= 1'b1;
                else if (raw_clr[i])
                    raw_reg[i] <= 1'b0;
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    ovf_reg[i] <= 1'b0;
                else if (ovf_event[i])
                    ovf_reg[i] <= 1'b1;
                else if (ovf_clr[i])
                    ovf_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_reg <= adcirq_pkg::RST_FLAGS;
        else if (wr_mask)
            mask_reg <= rb.wdata[3:0];
    end

    // Level output; stays up until the flag is cleared or masked off
    assign adc_irq = |masked;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Reserved bits read as zero; unmapped offsets read as zero
    always_comb
    begin
        rb.rdata = 32'h0000_0000;
        unique case (rb.addr)
            adcirq_pkg::OFF_RAW_STATUS:   rb.rdata[3:0] = raw_reg;
            adcirq_pkg::OFF_INT_MASK:     rb.rdata[3:0] = mask_reg;
            adcirq_pkg::OFF_MASKED_CLEAR: rb.rdata[3:0] = masked;
            adcirq_pkg::OFF_OVF_STATUS:   rb.rdata[3:0] = ovf_reg;
            default:                      rb.rdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_raw_set;
        @(posedge hclk) disable iff (!hresetn)
        raw_set != 4'h0 |=> ((raw_reg & $past(raw_set)) == $past(raw_set));
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("completion did not raise raw flag");

    property p_raw_poll;
        @(posedge hclk) disable iff (!hresetn)
        rb.rd_pulse && (rb.addr == adcirq_pkg::OFF_RAW_STATUS) |=> (hrdata[3:0] == $past(raw_reg));
    endproperty
    a_raw_poll: assert property (p_raw_poll) else $error("raw status read wrong");

    property p_mask_blocks;
        @(posedge hclk) disable iff (!hresetn)
        (mask_reg == 4'h0) |-> !adc_irq;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("interrupt raised with all masked");

    property p_masked_read;
        @(posedge hclk) disable iff (!hresetn)
        rb.rd_pulse && (rb.addr == adcirq_pkg::OFF_MASKED_CLEAR)
            |=> (hrdata[3:0] == ($past(raw_reg) & $past(mask_reg))) && hreadyout;
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked status read wrong");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        ((raw_reg & mask_reg) != 4'h0) && (raw_set == 4'h0) && !wr_clear && !wr_mask |=> adc_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level dropped early");

    property p_w1c_raw;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear |=> ((raw_reg & $past(raw_clr) & ~$past(raw_set)) == 4'h0);
    endproperty
    a_w1c_raw: assert property (p_w1c_raw) else $error("write one left raw flag set");

    property p_w0_keeps;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear |=> ((raw_reg & $past(raw_reg & ~raw_clr)) == $past(raw_reg & ~raw_clr));
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared raw flag");

    property p_poll_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear && ((raw_reg & ~mask_reg & rb.wdata[3:0]) != 4'h0) && (raw_set == 4'h0)
            |=> ((raw_reg & $past(rb.wdata[3:0])) == 4'h0);
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("unmasked clear ignored");

    property p_ovf_set;
        @(posedge hclk) disable iff (!hresetn)
        ovf_event != 4'h0 |=> ((ovf_reg & $past(ovf_event)) == $past(ovf_event));
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_ovf && (ovf_event == 4'h0) |=> (ovf_reg == ($past(ovf_reg) & ~$past(rb.wdata[3:0])));
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear wrong");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        rb.rd_pulse |=> (hrdata[31:4] == 28'h0000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_raw_ro;
        @(posedge hclk) disable iff (!hresetn)
        rb.wr_pulse && (rb.addr == adcirq_pkg::OFF_RAW_STATUS) |=> (raw_reg == ($past(raw_reg) | $past(raw_set)));
    endproperty
    a_raw_ro: assert property (p_raw_ro) else $error("write to raw status changed flags");

    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        ((raw_set & raw_clr) != 4'h0) |=> ((raw_reg & $past(raw_set & raw_clr)) == $past(raw_set & raw_clr));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_one_wait;
        @(posedge hclk) disable iff (!hresetn)
        hsel && (htrans == adcirq_pkg::HTRANS_NONSEQ) && hready && hreadyout |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("transfer not answered after one wait");

    property p_raw_no_spur;
        @(posedge hclk) disable iff (!hresetn)
        (raw_set == 4'h0) |=> ((raw_reg & ~$past(raw_reg)) == 4'h0);
    endproperty
    a_raw_no_spur: assert property (p_raw_no_spur) else $error("raw flag set without event");

    property p_raw_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (raw_set == 4'h0) && !wr_clear |=> (raw_reg == $past(raw_reg));
    endproperty
    a_raw_sticky: assert property (p_raw_sticky) else $error("raw flags changed without cause");

    property p_mask_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_mask |=> (mask_reg == $past(rb.wdata[3:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

    property p_mask_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_mask |=> (mask_reg == $past(mask_reg));
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write");

    property p_mask_read;
        @(posedge hclk) disable iff (!hresetn)
        rb.rd_pulse && (rb.addr == adcirq_pkg::OFF_INT_MASK) |=> (hrdata[3:0] == $past(mask_reg));
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

    property p_irq_rise;
        @(posedge hclk) disable iff (!hresetn)
        ((raw_set & mask_reg) != 4'h0) && !wr_mask |=> adc_irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("unmasked event gave no interrupt");

    property p_irq_drop;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear && ((raw_reg & mask_reg & ~rb.wdata[3:0]) == 4'h0) && (raw_set == 4'h0) && !wr_mask |=> !adc_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt held after clear");

    property p_ovf_no_spur;
        @(posedge hclk) disable iff (!hresetn)
        (ovf_event == 4'h0) |=> ((ovf_reg & ~$past(ovf_reg)) == 4'h0);
    endproperty
    a_ovf_no_spur: assert property (p_ovf_no_spur) else $error("overflow set without event");

    property p_ovf_read;
        @(posedge hclk) disable iff (!hresetn)
        rb.rd_pulse && (rb.addr == adcirq_pkg::OFF_OVF_STATUS) |=> (hrdata[3:0] == $past(ovf_reg));
    endproperty
    a_ovf_read: assert property (p_ovf_read) else $error("overflow read wrong");

    property p_ovf_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (ovf_event == 4'h0) && !wr_ovf |=> (ovf_reg == $past(ovf_reg));
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow changed without cause");

    property p_ovf_w0;
        @(posedge hclk) disable iff (!hresetn)
        wr_ovf |=> ((ovf_reg & $past(ovf_reg & ~ovf_clr)) == $past(ovf_reg & ~ovf_clr));
    endproperty
    a_ovf_w0: assert property (p_ovf_w0) else $error("zero write cleared overflow");

    property p_ovf_w1c;
        @(posedge hclk) disable iff (!hresetn)
        wr_ovf |=> ((ovf_reg & $past(ovf_clr) & ~$past(ovf_event)) == 4'h0);
    endproperty
    a_ovf_w1c: assert property (p_ovf_w1c) else $error("one write left overflow set");

    property p_raw_ro_mask;
        @(posedge hclk) disable iff (!hresetn)
        rb.wr_pulse && (rb.addr == adcirq_pkg::OFF_RAW_STATUS) |=> $stable(mask_reg);
    endproperty
    a_raw_ro_mask: assert property (p_raw_ro_mask) else $error("raw status write changed mask");

    property p_ovf_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        ((ovf_event & ovf_clr) != 4'h0) |=> ((ovf_reg & $past(ovf_event & ovf_clr)) == $past(ovf_event & ovf_clr));
    endproperty
    a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("overflow lost to clear");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    property p_cov_irq;
        @(posedge hclk) disable iff (!hresetn)
        !adc_irq ##1 adc_irq ##[1:20] wr_clear;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_race;
        @(posedge hclk) disable iff (!hresetn)
        (raw_set & raw_clr) != 4'h0;
    endproperty
    c_cov_race: cover property (p_cov_race);

    property p_cov_poll;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear && ((raw_reg & ~mask_reg) != 4'h0);
    endproperty
    c_cov_poll: cover property (p_cov_poll);

    property p_cov_ovf;
        @(posedge hclk) disable iff (!hresetn)
        ovf_event != 4'h0 ##[1:20] wr_ovf;
    endproperty
    c_cov_ovf: cover property (p_cov_ovf);

    property p_cov_drop;
        @(posedge hclk) disable iff (!hresetn)
        wr_clear && adc_irq ##1 !adc_irq;
    endproperty
    c_cov_drop: cover property (p_cov_drop);
endmodule

/* tb/adcirq_seq_model.sv */
// Model of the sequencer side: sample completions and per-sequencer result FIFOs
`timescale 1ns/1ns
module adcirq_seq_model
#(
    parameter int DEPTH = 2
)
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    output logic      [3:0] conv_done,
    output logic      [3:0] sample_irq_request,
    output logic      [3:0] fifo_wr_req,
    output logic      [3:0] fifo_full,
    input  wire logic [3:0] fifo_wr_en
);
    int fill [4];

    initial
    begin
        conv_done          = 4'h0;
        sample_irq_request = 4'h0;
        fifo_wr_req        = 4'h0;
    end

    // Only accepted writes are stored, so a dropped write leaves the level alone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!hresetn)
                fill[i] <= 0;
            else if (fifo_wr_en[i])
                fill[i] <= fill[i] + 1;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            fifo_full[i] = (fill[i] >= DEPTH);
    end

    task automatic complete(input int s, input logic ie);
        @(posedge hclk);
        conv_done[s]          <= 1'b1;
        sample_irq_request[s] <= ie;
        @(posedge hclk);
        conv_done[s]          <= 1'b0;
        // Released qualifier shows the inverse so a stale level cannot pass
        sample_irq_request[s] <= ~ie;
    endtask

    task automatic push(input int s);
        @(posedge hclk);
        fifo_wr_req[s] <= 1'b1;
        @(posedge hclk);
        fifo_wr_req[s] <= 1'b0;
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking testbench for the sequencer interrupt and overflow status block
`timescale 1ns/1ns
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        hreadyout;
    logic        hresp;
    logic        adc_irq;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  conv_done;
    logic [3:0]  sample_irq_request;
    logic [3:0]  fifo_wr_req;
    logic [3:0]  fifo_full;
    logic [3:0]  fifo_wr_en;
    int          miscompares;
    int          check_count;
    int          cycles;

    adcirq_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
        .sample_irq_request(sample_irq_request), .fifo_wr_req(fifo_wr_req), .fifo_full(fifo_full),
        .fifo_wr_en(fifo_wr_en), .adc_irq(adc_irq));

    adcirq_seq_model #(.DEPTH(2)) seq (.hclk(hclk), .hresetn(hresetn), .conv_done(conv_done),
        .sample_irq_request(sample_irq_request), .fifo_wr_req(fifo_wr_req), .fifo_full(fifo_full),
        .fifo_wr_en(fifo_wr_en));

    // ****************************************************************
    // Clock, timeout and bus tasks
    // ****************************************************************
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            $display("ERROR t=%0t run did not finish in time", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Ready is judged at the falling edge so the value is settled before the next rising edge acts
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge hclk);
        end
        if (n >= 20)
            chk(32'h0, 32'h1, "bus hung");
        @(posedge hclk);
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= adcirq_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'h0, "raw after reset");
        rchk(adcirq_pkg::OFF_INT_MASK, 32'h0, "mask after reset");
        rchk(adcirq_pkg::OFF_MASKED_CLEAR, 32'h0, "masked after reset");
        rchk(adcirq_pkg::OFF_OVF_STATUS, 32'h0, "overflow after reset");
        chk({31'h0, adc_irq}, 32'h0, "irq after reset");
        chk({31'h0, hresp}, 32'h0, "response code");
        $display("Test reset done");
    endtask

    task automatic t_poll();
        seq.complete(1, 1'b1);
        seq.complete(2, 1'b0);
        // Reserved bits are left as they read; the flag field write is ignored, as raw status is read-only
        bus(1'b1, adcirq_pkg::OFF_RAW_STATUS, 32'h0000_000F);
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'h2, "raw polled unmasked");
        rchk(adcirq_pkg::OFF_MASKED_CLEAR, 32'h0, "masked with mask off");
        chk({31'h0, adc_irq}, 32'h0, "irq blocked by mask");
        bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'h2);
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'h0, "raw cleared by poller");
        $display("Test poll done");
    endtask

    task automatic t_mask();
        // Reserved bits are written back as read, as software is expected to
        bus(1'b1, adcirq_pkg::OFF_INT_MASK, 32'h0000_0005);
        rchk(adcirq_pkg::OFF_INT_MASK, 32'h5, "mask readback");
        for (int s = 0; s < 4; s++)
            seq.complete(s, 1'b1);
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'hF, "all raw set");
        rchk(adcirq_pkg::OFF_MASKED_CLEAR, 32'h5, "masked is raw and mask");
        chk({31'h0, adc_irq}, 32'h1, "irq raised");
        bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'h1);
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'hE, "raw after one clear");
        chk({31'h0, adc_irq}, 32'h1, "irq held by seq2");
        bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'h0);
        rchk(adcirq_pkg::OFF_MASKED_CLEAR, 32'h4, "zero write keeps");
        bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'h4);
        chk({31'h0, adc_irq}, 32'h0, "irq dropped");
        bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'hA);
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'h0, "raw all cleared");
        $display("Test mask done");
    endtask

    task automatic t_overflow();
        for (int s = 0; s < 4; s++)
            repeat (2) seq.push(s);
        rchk(adcirq_pkg::OFF_OVF_STATUS, 32'h0, "no overflow when just full");
        seq.push(2);
        // Let the edge that sampled the request settle before reading the level
        @(negedge hclk);
        chk(seq.fill[2], 2, "dropped write not stored");
        rchk(adcirq_pkg::OFF_OVF_STATUS, 32'h4, "overflow flagged");
        bus(1'b1, adcirq_pkg::OFF_OVF_STATUS, 32'h0);
        rchk(adcirq_pkg::OFF_OVF_STATUS, 32'h4, "zero write keeps overflow");
        bus(1'b1, adcirq_pkg::OFF_OVF_STATUS, 32'h4);
        rchk(adcirq_pkg::OFF_OVF_STATUS, 32'h0, "overflow cleared");
        rchk(12'h014, 32'h0, "unmapped read");
        $display("Test overflow done");
    endtask

    // The completion lands on the edge where the clearing write updates the flags
    task automatic t_set_wins();
        seq.complete(0, 1'b1);
        fork
            bus(1'b1, adcirq_pkg::OFF_MASKED_CLEAR, 32'h1);
            begin
                @(posedge hclk);
                seq.complete(0, 1'b1);
            end
        join
        rchk(adcirq_pkg::OFF_RAW_STATUS, 32'h1, "set beats clear");
        $display("Test set priority done");
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        hwrite  = 1'b0;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        htrans  = 2'h0;
        hsize   = 3'h2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_poll();
        t_mask();
        t_overflow();
        t_set_wins();
        tally_and_finish();
    end
endmodule
